// ===== hdl/sadc_pkg.sv
package sadc_pkg;
    // ========================================
    // register map (byte addresses)
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_CFG      = 8'h04;
    localparam logic [7:0]  ADDR_CHAN     = 8'h08;
    localparam logic [7:0]  ADDR_PAIR     = 8'h0c;
    localparam logic [7:0]  ADDR_RES_HI   = 8'h10;
    localparam logic [7:0]  ADDR_RES_LO   = 8'h14;
    localparam logic [7:0]  ADDR_INT_ST   = 8'h18;
    localparam logic [7:0]  ADDR_INT_MASK = 8'h1c;

    // ========================================
    // control register fields
    localparam int CTL_EN    = 7;
    localparam int CTL_TM    = 6;
    localparam int CTL_DONE  = 5;
    localparam int CTL_BUSY  = 4;
    localparam int CTL_CM_HI = 3;
    localparam int CTL_CM_LO = 2;
    localparam int CTL_LJ    = 0;

    // ========================================
    // config register fields and reset
    localparam int         CFG_DIV_HI  = 7;
    localparam int         CFG_DIV_LO  = 3;
    localparam int         CFG_GAIN_HI = 2;
    localparam logic [4:0] DIV_RST     = 5'h1f;
    localparam logic [2:0] GAIN_UNITY  = 3'h0;
    localparam logic [3:0] TEMP_CHAN   = 4'h8;
    localparam int         INT_DONE    = 0;

    // ========================================
    // start sources and sequencer states
    typedef enum logic [1:0] {
        SADC_SRC_SW   = 2'b00,
        SADC_SRC_TMR3 = 2'b01,
        SADC_SRC_EXT  = 2'b10,
        SADC_SRC_TMR2 = 2'b11
    } sadc_src_t;

    typedef enum logic [1:0] {
        SADC_IDLE  = 2'b00,
        SADC_TRACK = 2'b01,
        SADC_CONV  = 2'b10
    } sadc_state_t;

    // ========================================
    // timing
    localparam int          CLK_NS         = 8;
    localparam logic [4:0]  CONV_SCLKS     = 5'd16;
    localparam logic [4:0]  TRACK_SCLKS    = 5'd3;
    localparam int          MIN_PERIOD_NS  = 10000;
    localparam logic [10:0] MIN_PERIOD_CYC =
        11'((MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS);

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : sadc_pkg

// ===== hdl/sadc_ctrl.sv
`timescale 1ns/1ps
module sadc_ctrl
    import sadc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    output      logic [1:0]        s_axi_bresp,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    output      logic [31:0]       s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              timer3_overflow,
    input  wire logic              timer2_overflow,
    input  wire logic              external_convert_start,
    input  wire logic              chip_standby,
    input  wire logic [9:0]        sar_result,
    output      logic              irq,
    output      logic              analog_power_on,
    output      logic              track_enable,
    output      logic              convert_active,
    output      logic              sar_clock_tick,
    output      logic [2:0]        gain_field,
    output      logic [3:0]        channel_address_field,
    output      logic              temp_sensor_select,
    output      logic              pair01_differential,
    output      logic              pair23_differential,
    output      logic              pair45_differential,
    output      logic              pair67_differential
);

    // ========================================
    // state
    // every flop of the block lives in this one struct, so reset is one clear plus
    // a few field loads, and register transfer stays a single statement
    typedef struct packed {
        logic        en;
        logic        tm;
        logic        done;
        logic        lj;
        logic [1:0]  cm;
        logic [4:0]  div;
        logic [2:0]  gain;
        logic [3:0]  chan;
        logic [3:0]  pair;
        logic [9:0]  res;
        logic        res_diff;
        logic        int_st;
        logic        int_mask;
        sadc_state_t st;
        logic [4:0]  dcnt;
        logic [4:0]  scnt;
        logic [10:0] rcnt;
        logic        ext_q;
        logic        awready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        irq;
        logic        pwr;
        logic        trk;
        logic        cnv;
        logic        tick;
        logic        tsel;
    } sadc_regs_t;

    sadc_regs_t q;
    sadc_regs_t d;

    // combinational helpers of the next-state pass
    logic       wr_go;
    logic       rd_go;
    logic       wr_lane;
    logic [7:0] wb;
    logic       sw_start;
    logic       trig;
    logic       accept;
    logic       tick;
    logic       diff_sel;
    logic [7:0] rd_byte;
    logic       rd_hit;

    // ========================================
    // next-state logic
    // one pass fills d from q and the pins; nothing here holds state
    always_comb begin
        d        = q;
        wb       = s_axi_wdata[7:0];
        wr_go    = q.awready && s_axi_awvalid && s_axi_wvalid;
        rd_go    = q.arready && s_axi_arvalid;
        wr_lane  = wr_go && s_axi_wstrb[0];
        sw_start = 1'b0;
        rd_byte  = 8'h00;
        rd_hit   = 1'b1;

        // bus handshake: one-cycle ready pulses, response held till taken
        // awready waits for both valids so address and data go in together;
        // a pending response blocks the next request of its kind
        d.awready = s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid;
        d.arready = s_axi_arvalid && !q.arready && !q.rvalid;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // register writes; only byte lane 0 carries data
        // a clear of done and a finishing conversion in one cycle:
        // the sequencer below assigns later, so the set wins
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            // unmapped offsets answer with an error and change nothing
            unique case (s_axi_awaddr)
                ADDR_CTRL, ADDR_CFG, ADDR_CHAN, ADDR_PAIR,
                ADDR_RES_HI, ADDR_RES_LO, ADDR_INT_ST, ADDR_INT_MASK: ;
                default: d.bresp = RESP_SLVERR;
            endcase
        end
        if (wr_lane) begin
            unique case (s_axi_awaddr)
                ADDR_CTRL: begin
                    d.en   = wb[CTL_EN];
                    d.tm   = wb[CTL_TM];
                    d.done = wb[CTL_DONE];
                    d.cm   = wb[CTL_CM_HI:CTL_CM_LO];
                    d.lj   = wb[CTL_LJ];
                    sw_start = wb[CTL_BUSY];
                end
                ADDR_CFG: begin
                    d.div  = wb[CFG_DIV_HI:CFG_DIV_LO];
                    d.gain = wb[CFG_GAIN_HI:0];
                end
                ADDR_CHAN:     d.chan = wb[3:0];
                ADDR_PAIR:     d.pair = wb[3:0];
                ADDR_INT_ST:   d.int_st = q.int_st & ~wb[INT_DONE];
                ADDR_INT_MASK: d.int_mask = wb[INT_DONE];
                default: ;
            endcase
        end

        // trigger selection and edge detect on the convert-start pin
        // timer overflows arrive as one-cycle pulses and are used raw;
        // the pin is sampled once so only a low-to-high step counts
        d.ext_q = external_convert_start;
        unique case (sadc_src_t'(q.cm))
            SADC_SRC_SW:   trig = sw_start;
            SADC_SRC_TMR3: trig = timer3_overflow;
            SADC_SRC_EXT:  trig = external_convert_start && !q.ext_q;
            SADC_SRC_TMR2: trig = timer2_overflow;
        endcase
        // busy drops a trigger; spacing counter caps rate
        accept = trig && q.en && q.st == SADC_IDLE && q.rcnt == 11'd0;

        // conversion clock: one tick every div+1 system clocks
        // the divider reloads while idle, so every conversion starts
        // with a full first period whatever the count held before
        tick = (q.dcnt == 5'd0);
        if (q.st == SADC_IDLE) begin
            tick   = 1'b0;
            d.dcnt = q.div;
        end else if (tick) begin
            d.dcnt = q.div;
        end else begin
            d.dcnt = q.dcnt - 5'd1;
        end
        // start spacing counter; runs down in every state
        if (q.rcnt != 11'd0) begin
            d.rcnt = q.rcnt - 11'd1;
        end

        // selected channel is differential when its pair bit is set
        // the temperature channel never belongs to a pair
        diff_sel = !q.chan[3] && q.pair[q.chan[2:1]];

        // sequencer
        // idle waits for an accepted trigger; track counts its ticks in
        // low-power mode; conv counts sixteen ticks and latches the code
        unique case (q.st)
            SADC_IDLE: begin
                if (accept) begin
                    d.rcnt = MIN_PERIOD_CYC - 11'd1;
                    // the pin edge itself ends tracking, so no extra track
                    if (q.tm && sadc_src_t'(q.cm) != SADC_SRC_EXT) begin
                        d.st   = SADC_TRACK;
                        d.scnt = TRACK_SCLKS - 5'd1;
                    end else begin
                        d.st   = SADC_CONV;
                        d.scnt = CONV_SCLKS - 5'd1;
                    end
                end
            end
            SADC_TRACK: begin
                // low-power track phase: three conversion clocks, then convert
                if (tick) begin
                    if (q.scnt == 5'd0) begin
                        d.st   = SADC_CONV;
                        d.scnt = CONV_SCLKS - 5'd1;
                    end else begin
                        d.scnt = q.scnt - 5'd1;
                    end
                end
            end
            SADC_CONV: begin
                if (tick) begin
                    if (q.scnt == 5'd0) begin
                        d.st       = SADC_IDLE;
                        d.res_diff = diff_sel;
                        // offset code to two's complement: flip the msb
                        d.res      = diff_sel ? {~sar_result[9], sar_result[8:0]}
                                              : sar_result;
                        d.done     = 1'b1;
                        d.int_st   = 1'b1;
                    end else begin
                        d.scnt = q.scnt - 5'd1;
                    end
                end
            end
            default: d.st = SADC_IDLE;
        endcase
        // disabling aborts any conversion in flight
        // limitation: an aborted conversion leaves done and result as they were
        if (!d.en) begin
            d.st = SADC_IDLE;
        end

        // register reads
        // the read word is decoded every cycle and latched only at the
        // accept, so the master may move the address once arready is seen
        unique case (s_axi_araddr)
            ADDR_CTRL: rd_byte = {q.en, q.tm, q.done, q.st != SADC_IDLE,
                                  q.cm, 1'b0, q.lj};
            ADDR_CFG:  rd_byte = {q.div, q.gain};
            ADDR_CHAN: rd_byte = {4'h0, q.chan};
            ADDR_PAIR: rd_byte = {4'h0, q.pair};
            ADDR_RES_HI: begin
                if (q.lj) begin
                    rd_byte = q.res[9:2];
                end else begin
                    rd_byte = {{6{q.res_diff & q.res[9]}}, q.res[9:8]};
                end
            end
            ADDR_RES_LO:   rd_byte = q.lj ? {q.res[1:0], 6'h00} : q.res[7:0];
            ADDR_INT_ST:   rd_byte = {7'h00, q.int_st};
            ADDR_INT_MASK: rd_byte = {7'h00, q.int_mask};
            default:       rd_hit = 1'b0;
        endcase
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rdata  = {24'h000000, rd_byte};
            d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // analog-side controls, registered
        d.pwr  = d.en;
        d.cnv  = d.st == SADC_CONV;
        // no tick goes out in the cycle enable drops, so the analog core
        // never sees a clock edge while it powers down
        d.tick = tick && d.en;
        // when enabled and out of chip standby, mode 0 tracks whenever idle; mode 1 only in its track phase
        // or, for pin triggering, while the pin is low
        d.trk  = d.en && !chip_standby &&
                 ((d.st == SADC_IDLE && !d.tm) ||
                  d.st == SADC_TRACK ||
                  (d.st == SADC_IDLE && d.tm && sadc_src_t'(d.cm) == SADC_SRC_EXT &&
                   !external_convert_start));
        d.tsel = d.chan[3];
        d.irq  = d.int_st && d.int_mask;
    end

    // ========================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q      <= '0;
            q.st   <= SADC_IDLE;
            q.div  <= DIV_RST;
            q.dcnt <= DIV_RST;
            q.gain <= GAIN_UNITY;
            q.pair <= 4'h0;
            // pin taken as high, so a pin held high through reset is no edge
            q.ext_q <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // outputs, all from flops
    // one wire per pair bit, so the analog switches need no decode
    assign s_axi_awready         = q.awready;
    assign s_axi_wready          = q.awready;
    assign s_axi_bvalid          = q.bvalid;
    assign s_axi_bresp           = q.bresp;
    assign s_axi_arready         = q.arready;
    assign s_axi_rvalid          = q.rvalid;
    assign s_axi_rdata           = q.rdata;
    assign s_axi_rresp           = q.rresp;
    assign irq                   = q.irq;
    assign analog_power_on       = q.pwr;
    assign track_enable          = q.trk;
    assign convert_active        = q.cnv;
    assign sar_clock_tick        = q.tick;
    assign gain_field            = q.gain;
    assign channel_address_field = q.chan;
    assign temp_sensor_select    = q.tsel;
    assign pair01_differential   = q.pair[0];
    assign pair23_differential   = q.pair[1];
    assign pair45_differential   = q.pair[2];
    assign pair67_differential   = q.pair[3];

endmodule : sadc_ctrl

// ===== bench/sadc_ctrl_asserts.sv
`timescale 1ns/1ps
module sadc_ctrl_asserts (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       chip_standby,
    input wire logic       analog_power_on,
    input wire logic       track_enable,
    input wire logic       convert_active,
    input wire logic       sar_clock_tick,
    input wire logic [3:0] channel_address_field,
    input wire logic       temp_sensor_select
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ========================================
    // helpers: ticks inside a conversion, cycles between conversion starts
    logic [4:0]  ticks_q;
    logic [15:0] gap_q;
    logic        conv_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ticks_q <= 5'h00;
            gap_q   <= 16'hffff;
            conv_q  <= 1'b0;
        end else begin
            conv_q  <= convert_active;
            ticks_q <= convert_active ? ticks_q + 5'(sar_clock_tick) : 5'h00;
            // saturate so a long idle spell never wraps into a short gap
            gap_q   <= (convert_active && !conv_q) ? 16'h0001
                     : (gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001;
        end
    end
    // ========================================
    // named sequences for the multi-step behaviours
    sequence s_power_off; !analog_power_on ##1 !analog_power_on; endsequence
    sequence s_standby;   chip_standby ##1 chip_standby;         endsequence
    sequence s_converting; convert_active ##1 convert_active;    endsequence
    sequence s_conv_end;  $fell(convert_active) && analog_power_on; endsequence
    AST_PWR_CONV: assert property (convert_active |-> analog_power_on)
        else $error("conversion running with analog power off");
    AST_OFF_NO_TRACK: assert property (s_power_off |-> !track_enable)
        else $error("tracking while subsystem shut down");
    AST_TEMP_SEL: assert property (temp_sensor_select == channel_address_field[3])
        else $error("temperature sensor select disagrees with channel");
    AST_TICK_PWR: assert property (sar_clock_tick |-> analog_power_on)
        else $error("conversion clock ticks while disabled");
    AST_CONV_LEN: assert property (s_conv_end |-> ticks_q inside {[5'd15:5'd17]})
        else $error("conversion did not last sixteen clocks");
    AST_TRACK_CONV: assert property (s_converting |-> !track_enable)
        else $error("tracking during conversion");
    AST_STANDBY: assert property (s_standby |-> !track_enable)
        else $error("tracking during chip standby");
    AST_RATE: assert property (convert_active && !conv_q |-> gap_q >= 16'd1150)
        else $error("conversions started too close together");
endmodule : sadc_ctrl_asserts
bind sadc_ctrl sadc_ctrl_asserts sadc_ctrl_asserts_i (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .chip_standby          (chip_standby),
    .analog_power_on       (analog_power_on),
    .track_enable          (track_enable),
    .convert_active        (convert_active),
    .sar_clock_tick        (sar_clock_tick),
    .channel_address_field (channel_address_field),
    .temp_sensor_select    (temp_sensor_select)
);

// ===== bench/sadc_ctrl_test.sv
`timescale 1ns/1ps
module sadc_ctrl_test;
    import sadc_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, timer3_overflow, timer2_overflow, external_convert_start;
    logic        chip_standby, irq, analog_power_on, track_enable, convert_active;
    logic        sar_clock_tick, temp_sensor_select, pair01_differential;
    logic        pair23_differential, pair45_differential, pair67_differential;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, channel_address_field;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
    logic [9:0]  sar_result;
    logic [2:0]  gain_field;
    int          failures, total_checks;
    // conversion table: control, channel, raw code, expected high and low bytes
    logic [7:0]  ctl_t [4] = '{8'h90, 8'hcd, 8'h84, 8'hc8};
    logic [7:0]  chan_t [4] = '{8'h03, 8'h00, 8'h00, 8'h03};
    logic [9:0]  res_t [4] = '{10'h2a5, 10'h2a5, 10'h3ff, 10'h155};
    logic [7:0]  hi_t [4] = '{8'h02, 8'h29, 8'h01, 8'h01};
    logic [7:0]  lo_t [4] = '{8'ha5, 8'h40, 8'hff, 8'h55};
    sadc_ctrl sadc_ctrl_i (.*);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // ========================================
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // ========================================
    // bus master; each task starts a cycle after the previous one ended
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        b = s_axi_bresp;
        if (n >= 100) begin
            failures++;
            conclude();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 100) begin
            failures++;
            conclude();
        end
    endtask : rd
    // start a conversion from the source selected in the control value
    task automatic fire(input logic [7:0] c);
        if (c[3:2] == 2'b00) wr(ADDR_CTRL, {24'h0, c});
        @(posedge aclk);
        timer3_overflow <= (c[3:2] == 2'b01);
        timer2_overflow <= (c[3:2] == 2'b11);
        external_convert_start <= (c[3:2] == 2'b10);
        @(posedge aclk);
        timer3_overflow <= 1'b0;
        timer2_overflow <= 1'b0;
    endtask : fire
    // ========================================
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, timer3_overflow, timer2_overflow, external_convert_start} = '0;
        {chip_standby, s_axi_awaddr, s_axi_araddr, s_axi_wdata, sar_result} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CFG);
        check(d, 32'h0000_00f8);
        check(32'(r), 32'(RESP_OKAY));
        rd(ADDR_PAIR);
        check(d, 32'h0);
        check(32'({gain_field, analog_power_on}), 32'h0);
        rd(8'h20);
        check(d, 32'h0);
        check(32'(r), 32'(RESP_SLVERR));
        wr(8'h24, 32'h0);
        check(32'(b), 32'(RESP_SLVERR));
        // divider field 1 so the conversion clock runs at half rate
        wr(ADDR_CFG, 32'h0d);
        wr(ADDR_PAIR, 32'h05);
        wr(ADDR_CHAN, 32'h08);
        check(32'(b), 32'(RESP_OKAY));
        repeat (2) @(posedge aclk);
        check(32'(gain_field), 32'h5);
        check(32'({pair67_differential, pair45_differential}), 32'h1);
        check(32'({pair23_differential, pair01_differential}), 32'h1);
        check(32'(temp_sensor_select), 32'h1);
        check(32'(channel_address_field), 32'h8);
        $display("test reset and configuration done");
        for (int i = 0; i < 4; i++) begin
            repeat (1300) @(posedge aclk);
            sar_result <= res_t[i];
            external_convert_start <= 1'b0;
            wr(ADDR_CHAN, {24'h0, chan_t[i]});
            wr(ADDR_CTRL, {24'h0, ctl_t[i] & 8'hef});
            // idle tracking: always in mode 0, pin-low only for pin starts in mode 1
            check(32'(track_enable),
                  32'(!ctl_t[i][6] || ctl_t[i][3:2] == 2'b10));
            fire(ctl_t[i]);
            d = 32'h0;
            if (i == 0) begin
                // divider field 1: a conversion clock tick every second cycle
                for (int n = 0; n < 8 && sar_clock_tick !== 1'b1; n++) @(posedge aclk);
                @(posedge aclk);
                check(32'(sar_clock_tick), 32'h0);
                @(posedge aclk);
                check(32'(sar_clock_tick), 32'h1);
                rd(ADDR_CTRL);
                check(32'(d[4]), 32'h1);
                check(32'(convert_active), 32'h1);
            end
            // poll the done flag, as software would; stale data must not end it
            for (int n = 0; n < 200 && d[5] !== 1'b1; n++) rd(ADDR_CTRL);
            check(32'(d[5:4]), 32'h2);
            if (i == 3) check(32'(track_enable), 32'h0);
            rd(ADDR_RES_HI);
            check(d, {24'h0, hi_t[i]});
            rd(ADDR_RES_LO);
            check(d, {24'h0, lo_t[i]});
            $display("test conversion %0d done", i);
        end
        // a timer start inside the spacing window must be dropped
        wr(ADDR_CTRL, 32'h84);
        fire(8'h84);
        repeat (40) @(posedge aclk);
        rd(ADDR_CTRL);
        check(32'(d[5:4]), 32'h0);
        $display("test start spacing done");
        check(32'(irq), 32'h0);
        wr(ADDR_INT_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h1);
        wr(ADDR_INT_ST, 32'h1);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0);
        $display("test interrupt done");
        wr(ADDR_CTRL, 32'h80);
        repeat (3) @(posedge aclk);
        check(32'(track_enable), 32'h1);
        check(32'(analog_power_on), 32'h1);
        chip_standby <= 1'b1;
        repeat (3) @(posedge aclk);
        check(32'(track_enable), 32'h0);
        chip_standby <= 1'b0;
        wr(ADDR_CTRL, 32'h00);
        repeat (3) @(posedge aclk);
        check(32'({analog_power_on, track_enable}), 32'h0);
        $display("test tracking and shutdown done");
        conclude();
    end
endmodule : sadc_ctrl_test
